// ==== hw/fpec_map.vh ====
// Register offsets, field positions, reset values and timing counts of the flash program/erase controller
`ifndef FPEC_MAP_VH
`define FPEC_MAP_VH

// ==========================================
// Register byte offsets on APB
`define FPEC_OFS_CTRL 12'h000
`define FPEC_OFS_KEY 12'h004
`define FPEC_OFS_STAT 12'h008
`define FPEC_OFS_BUF_ADDR 12'h00C
`define FPEC_OFS_BUF_LO 12'h010
`define FPEC_OFS_BUF_HI 12'h014
`define FPEC_OFS_FLASH_ADDR 12'h018

// ==========================================
// Control register fields
`define FPEC_BIT_START 15
`define FPEC_BIT_PEN 14
`define FPEC_BIT_ERR 13
`define FPEC_BIT_ERASE 6
`define FPEC_OP_HI 3
`define FPEC_OP_LO 0
`define FPEC_CTRL_RESET 16'h0000
`define FPEC_CTRL_MASK 16'hE04F

// ==========================================
// Unlock keys
`define FPEC_KEY1 8'h55
`define FPEC_KEY2 8'hAA

// ==========================================
// Operation codes
`define FPEC_OP_BULK 4'b1111
`define FPEC_OP_GSEG 4'b1101
`define FPEC_OP_SSEG 4'b1100
`define FPEC_OP_WORD 4'b0011
`define FPEC_OP_PAGE 4'b0010
`define FPEC_OP_ROW 4'b0001
`define FPEC_OP_CFG 4'b0000

// Action codes driven to the flash array
`define FPEC_ACT_NONE 3'd0
`define FPEC_ACT_BULK_ERASE 3'd1
`define FPEC_ACT_GSEG_ERASE 3'd2
`define FPEC_ACT_SSEG_ERASE 3'd3
`define FPEC_ACT_PAGE_ERASE 3'd4
`define FPEC_ACT_CFG_ERASE 3'd5
`define FPEC_ACT_WORD_PROG 3'd6
`define FPEC_ACT_ROW_PROG 3'd7
// Config byte program shares code 5 with config erase; no erase select goes out to the array, so the two reach it as one action
`define FPEC_ACT_CFG_PROG_SEL 3'd5

// ==========================================
// Timing and geometry
`define FPEC_OP_TIME_US 4000
`define FPEC_CLK_MHZ 25
`define FPEC_OP_CYCLES (`FPEC_OP_TIME_US * `FPEC_CLK_MHZ)
`define FPEC_ROW_WORDS 64
`define FPEC_PAGE_WORDS 512

`endif

// ==== hw/fpec_opdec.v ====
// Operation code decoder of the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
`include "fpec_map.vh"

module fpec_opdec (
   input wire erase_sel,
   input wire [3:0] op_code,
   output reg [2:0] action
);

   // ==========================================
   // Decode; unlisted codes and no-operation codes give no action
   always @* begin
      action = `FPEC_ACT_NONE;
      if (erase_sel) begin
         case (op_code)
            `FPEC_OP_BULK: action = `FPEC_ACT_BULK_ERASE;
            `FPEC_OP_GSEG: action = `FPEC_ACT_GSEG_ERASE;
            `FPEC_OP_SSEG: action = `FPEC_ACT_SSEG_ERASE;
            `FPEC_OP_PAGE: action = `FPEC_ACT_PAGE_ERASE;
            `FPEC_OP_CFG: action = `FPEC_ACT_CFG_ERASE;
            default: action = `FPEC_ACT_NONE;
         endcase
      end else begin
         case (op_code)
            `FPEC_OP_WORD: action = `FPEC_ACT_WORD_PROG;
            `FPEC_OP_ROW: action = `FPEC_ACT_ROW_PROG;
            `FPEC_OP_CFG: action = `FPEC_ACT_CFG_PROG_SEL;
            default: action = `FPEC_ACT_NONE;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== hw/fpec_hold_buf.v ====
// Holding buffer for one row of program words
`timescale 1ns/10ps
`default_nettype none
`include "fpec_map.vh"

module fpec_hold_buf #(
   parameter DEPTH = `FPEC_ROW_WORDS,
   parameter AW = 6
) (
   input wire mclk,
   input wire rst_n,
   input wire wr_lo,
   input wire wr_hi,
   input wire [AW-1:0] idx,
   input wire [15:0] lo_data,
   input wire [7:0] hi_data,
   input wire [AW-1:0] rd_idx,
   output reg [23:0] rd_word_q
);

   reg [15:0] lo_mem [0:DEPTH-1];
   reg [7:0] hi_mem [0:DEPTH-1];

   // ==========================================
   // Word halves written separately; array holds no reset so it maps to RAM
   always @(posedge mclk) begin
      if (wr_lo) begin
         lo_mem[idx] <= lo_data;
      end
      if (wr_hi) begin
         hi_mem[idx] <= hi_data;
      end
   end

   // Registered read port toward the flash array
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_word_q <= 24'h00_0000;
      end else begin
         rd_word_q <= {hi_mem[rd_idx], lo_mem[rd_idx]};
      end
   end

endmodule
`default_nettype wire

// ==== hw/fpec_top.v ====
// Flash program/erase controller with APB register file
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fpec_map.vh"

module fpec_top #(
   parameter OP_CYCLES = `FPEC_OP_CYCLES,
   parameter FA_W = 24
) (
   input wire mclk,
   input wire rst_n,
   input wire por_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire cpu_stall,
   output reg flash_go_q,
   output reg [2:0] flash_action_q,
   output reg [FA_W-1:0] flash_addr_q,
   output wire [23:0] flash_row_word,
   input wire [5:0] flash_row_idx,
   input wire flash_done
);

   localparam ST_IDLE = 2'd0;
   localparam ST_BUSY = 2'd1;
   localparam ST_WAIT = 2'd2;
   localparam [31:0] PAGE_UNIT = `FPEC_PAGE_WORDS;
   localparam [31:0] ROW_UNIT = `FPEC_ROW_WORDS;

   // ==========================================
   // Decode helpers
   function is_write_to;
      input [11:0] a;
      input [11:0] ofs;
      begin
         is_write_to = (a == ofs);
      end
   endfunction

   function [FA_W-1:0] align_down;
      input [FA_W-1:0] a;
      input [FA_W-1:0] unit;
      begin
         align_down = a - (a % unit);
      end
   endfunction

   // ==========================================
   // State
   reg [1:0] state_q;
   reg [31:0] tmr_q;
   reg start_q;
   reg pen_q;
   reg err_q;
   reg erase_q;
   reg [3:0] op_q;
   reg [1:0] key_q;
   reg [FA_W-1:0] buf_addr_q;
   reg [15:0] lo_hold_q;
   wire [2:0] action;

   wire acc = psel && penable;
   wire wr_en = acc && pwrite;
   wire rd_en = acc && !pwrite;
   wire busy = (state_q != ST_IDLE);
   wire wr_ctrl = wr_en && is_write_to(paddr, `FPEC_OFS_CTRL);
   wire wr_key = wr_en && is_write_to(paddr, `FPEC_OFS_KEY);
   wire wr_blo = wr_en && is_write_to(paddr, `FPEC_OFS_BUF_LO);
   wire wr_bhi = wr_en && is_write_to(paddr, `FPEC_OFS_BUF_HI);
   wire wr_badr = wr_en && is_write_to(paddr, `FPEC_OFS_BUF_ADDR);
   wire mapped = (paddr == `FPEC_OFS_CTRL) || (paddr == `FPEC_OFS_KEY) ||
      (paddr == `FPEC_OFS_STAT) || (paddr == `FPEC_OFS_BUF_ADDR) ||
      (paddr == `FPEC_OFS_BUF_LO) || (paddr == `FPEC_OFS_BUF_HI) ||
      (paddr == `FPEC_OFS_FLASH_ADDR);
   wire start_req = wr_ctrl && pwdata[`FPEC_BIT_START] && !busy;
   wire unlocked = (key_q == 2'd2);
   wire launch = start_req && unlocked && pen_q;
   wire reject = start_req && !launch;
   wire timer_end = (tmr_q == 32'h0000_0001);

   // Zero wait states; the bus answers in the access cycle
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   // Core held off for the whole self-timed operation
   assign cpu_stall = busy;

   fpec_opdec u_dec (
      .erase_sel(erase_q),
      .op_code(op_q),
      .action(action)
   );

   fpec_hold_buf #(
      .DEPTH(`FPEC_ROW_WORDS),
      .AW(6)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_lo(wr_bhi && !busy),
      .wr_hi(wr_bhi && !busy),
      .idx(buf_addr_q[5:0]),
      .lo_data(lo_hold_q),
      .hi_data(pwdata[7:0]),
      .rd_idx(flash_row_idx),
      .rd_word_q(flash_row_word)
   );

   // ==========================================
   // Unlock key tracker: any other access breaks the pair
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         key_q <= 2'd0;
      end else if (acc) begin
         if (wr_key && pwdata[7:0] == `FPEC_KEY1) begin
            key_q <= 2'd1;
         end else if (wr_key && key_q == 2'd1 && pwdata[7:0] == `FPEC_KEY2) begin
            key_q <= 2'd2;
         end else if (wr_ctrl && key_q == 2'd2) begin
            key_q <= 2'd0;
         end else begin
            key_q <= 2'd0;
         end
      end
   end

   // ==========================================
   // Control bits; only power-on reset clears them
   always @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         pen_q <= 1'b0;
         erase_q <= 1'b0;
         op_q <= 4'h0;
         err_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            pen_q <= pwdata[`FPEC_BIT_PEN];
            if (!busy) begin
               erase_q <= pwdata[`FPEC_BIT_ERASE];
               op_q <= pwdata[`FPEC_OP_HI:`FPEC_OP_LO];
            end
         end
         // Start is set only, cleared only by hardware
         if (launch) begin
            start_q <= 1'b1;
         end else if (state_q == ST_WAIT) begin
            start_q <= 1'b0;
         end
         // Error: hardware set beats a software clear in the same cycle
         if (reject) begin
            err_q <= 1'b1;
         end else if (launch) begin
            err_q <= 1'b0;
         end else if (wr_ctrl) begin
            err_q <= pwdata[`FPEC_BIT_ERR];
         end
      end
   end

   // ==========================================
   // Buffer address pointer and low-word staging
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         buf_addr_q <= {FA_W{1'b0}};
         lo_hold_q <= 16'h0000;
      end else if (!busy) begin
         if (wr_badr) begin
            buf_addr_q <= pwdata[FA_W-1:0];
         end else if (wr_bhi) begin
            buf_addr_q <= buf_addr_q + {{(FA_W-1){1'b0}}, 1'b1};
         end
         if (wr_blo) begin
            lo_hold_q <= pwdata[15:0];
         end
      end
   end

   // ==========================================
   // Self-timed sequencer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         tmr_q <= 32'h0000_0000;
         flash_go_q <= 1'b0;
         flash_action_q <= `FPEC_ACT_NONE;
         flash_addr_q <= {FA_W{1'b0}};
      end else begin
         flash_go_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (launch) begin
                  state_q <= ST_BUSY;
                  tmr_q <= OP_CYCLES;
                  flash_go_q <= (action != `FPEC_ACT_NONE);
                  flash_action_q <= action;
                  if (action == `FPEC_ACT_PAGE_ERASE) begin
                     flash_addr_q <= align_down(buf_addr_q, PAGE_UNIT[FA_W-1:0]);
                  end else if (action == `FPEC_ACT_ROW_PROG) begin
                     flash_addr_q <= align_down(buf_addr_q - 1'b1, ROW_UNIT[FA_W-1:0]);
                  end else begin
                     flash_addr_q <= buf_addr_q;
                  end
               end
            end
            ST_BUSY: begin
               tmr_q <= tmr_q - 32'h0000_0001;
               if (timer_end || flash_done) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               state_q <= ST_IDLE;
               flash_action_q <= `FPEC_ACT_NONE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Read mux; key reads zero, unused bits zero
   always @* begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         case (paddr)
            `FPEC_OFS_CTRL: prdata = {16'h0000, start_q, pen_q, err_q, 6'b00_0000, erase_q,
               2'b00, op_q};
            `FPEC_OFS_STAT: prdata = {28'h000_0000, key_q, busy, flash_go_q};
            `FPEC_OFS_BUF_ADDR: prdata = {{(32-FA_W){1'b0}}, buf_addr_q};
            `FPEC_OFS_FLASH_ADDR: prdata = {{(32-FA_W){1'b0}}, flash_addr_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== tb/fpec_chk_sva.sv ====
// Port-level assertions for the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
`include "fpec_map.vh"
module fpec_chk #(
   parameter int OP_CYCLES = 20
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_stall,
   input wire logic flash_go_q,
   input wire logic [2:0] flash_action_q,
   input wire logic flash_done
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   int unsigned cnt_q;
   wire logic rd_ctrl = psel && penable && !pwrite && paddr == `FPEC_OFS_CTRL;
   // ==========================================
   // Stall length counter, so the 4 ms bound needs no long repetition
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 0;
      else cnt_q <= cpu_stall ? cnt_q + 1 : 0;
   end
   stall_max_a: assert property (cnt_q <= OP_CYCLES + 1) else $error("stall too long");
   stall_min_a: assert property ($fell(cpu_stall) && !$past(flash_done) && !$past(flash_done, 2)
      |-> $past(cnt_q) >= OP_CYCLES - 1) else $error("stall too short");
   go_stall_a: assert property (flash_go_q |-> ##[0:1] cpu_stall) else $error("launch without stall");
   go_pulse_a: assert property (flash_go_q |=> !flash_go_q) else $error("launch pulse too long");
   go_defined_a: assert property (flash_go_q |-> flash_action_q != 3'd0) else $error("launch of no action");
   busy_reads_a: assert property (rd_ctrl && cpu_stall |-> prdata[15]) else $error("start bit low while busy");
   zero_bits_a: assert property (rd_ctrl |-> prdata[12:7] == 6'h00 && prdata[5:4] == 2'b00
      && prdata[31:16] == 16'h0000) else $error("unused control bits set");
   key_upper_a: assert property (psel && penable && !pwrite && paddr == `FPEC_OFS_KEY
      |-> prdata[15:8] == 8'h00) else $error("key upper byte set");
   busy_hold_a: assert property (cpu_stall && $past(cpu_stall) |-> $stable(flash_action_q))
      else $error("action changed while busy");
   unmapped_a: assert property (psel && penable && paddr > `FPEC_OFS_FLASH_ADDR |-> pready && pslverr)
      else $error("unmapped access not flagged");
   op_cov: cover property (flash_go_q);
   done_cov: cover property (flash_done && cpu_stall);
   busy_rd_cov: cover property (rd_ctrl && cpu_stall);
endmodule
bind fpec_top fpec_chk #(.OP_CYCLES(OP_CYCLES)) chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_go_q(flash_go_q),
   .flash_action_q(flash_action_q), .flash_done(flash_done));
`default_nettype wire

// ==== tb/fpec_flash_model.sv ====
// Flash array model: counts launches and reads back the holding buffer
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fast,
   input wire logic go,
   input wire logic [2:0] act,
   input wire logic [23:0] row_word,
   output logic [5:0] row_idx,
   output logic done,
   output int go_cnt,
   output logic [2:0] last_act,
   output logic [23:0] w0,
   output logic [23:0] w1
);
   logic [7:0] c_q;
   // Buffer word comes one cycle after its index, so capture is one step late
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         c_q <= 8'hFF;
         go_cnt <= 0;
         last_act <= 3'd0;
      end else begin
         if (go) begin
            c_q <= 8'h00;
            go_cnt <= go_cnt + 1;
            last_act <= act;
         end else if (c_q != 8'hFF) c_q <= c_q + 8'h01;
         if (c_q == 8'h01) w0 <= row_word;
         if (c_q == 8'h02) w1 <= row_word;
      end
   end
   // Sequential index walk; early finish only when asked to answer promptly
   assign row_idx = c_q[5:0];
   assign done = fast && c_q == 8'h04;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
`include "fpec_map.vh"
module testbench;
   logic mclk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, fast = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, cpu_stall, go, done, er;
   logic [2:0] act, last_act;
   logic [23:0] rw, w0, w1;
   logic [5:0] ridx;
   int go_cnt, miscompares = 0, checks_done = 0;
   fpec_top #(.OP_CYCLES(20)) dut_u (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_go_q(go),
      .flash_action_q(act), .flash_addr_q(), .flash_row_word(rw), .flash_row_idx(ridx),
      .flash_done(done));
   fpec_flash_model fm_u (.mclk(mclk), .rst_n(rst_n), .fast(fast), .go(go), .act(act),
      .row_word(rw), .row_idx(ridx), .done(done), .go_cnt(go_cnt), .last_act(last_act),
      .w0(w0), .w1(w1));
   // ==========================================
   // Clock and common tasks
   initial forever #20 mclk = ~mclk;
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // Request held until pready is sampled high; read data taken at that same edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      if (n >= 50) miscompares++;
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (cpu_stall !== 1'b0 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk(cpu_stall, 1'b0);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task t_regs;
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 0);
      apb(0, `FPEC_OFS_KEY, 0); chk(rd[15:8], 0);
      apb(1, `FPEC_OFS_CTRL, 32'h0000_0FBF);
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 32'h0000_000F);
      apb(0, 12'h020, 0); chk(er, 1'b1);
      $display("regs done");
   endtask
   // Start without keys, then with enable clear: both refused with error
   task t_err;
      apb(1, `FPEC_OFS_CTRL, 32'h0000_4042);
      apb(1, `FPEC_OFS_CTRL, 32'h0000_C042);
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 32'h0000_6042);
      apb(1, `FPEC_OFS_CTRL, 32'h0000_0042);
      apb(1, `FPEC_OFS_KEY, 32'h0000_0055);
      apb(1, `FPEC_OFS_KEY, 32'h0000_00AA);
      apb(1, `FPEC_OFS_CTRL, 32'h0000_8042);
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 32'h0000_2042);
      chk(go_cnt, 0);
      $display("error done");
   endtask
   task run_op(input logic e, input logic [3:0] op, input logic [2:0] xa);
      logic [15:0] c;
      int g;
      c = {2'b01, 7'h00, e, 2'b00, op};
      g = go_cnt;
      apb(1, `FPEC_OFS_CTRL, c);
      apb(1, `FPEC_OFS_KEY, 32'h0000_0055);
      apb(1, `FPEC_OFS_KEY, 32'h0000_00AA);
      apb(1, `FPEC_OFS_CTRL, c | 16'h8000);
      // Let the launch edge settle before looking at the stall
      @(negedge mclk);
      if (xa != 3'd0) begin
         chk(cpu_stall, 1'b1);
         apb(1, `FPEC_OFS_CTRL, c ^ 16'h004F);
         apb(0, `FPEC_OFS_CTRL, 0); chk(rd[15], 1'b1);
         wait_idle;
         apb(0, `FPEC_OFS_CTRL, 0); chk(rd, c);
         chk(last_act, xa);
         chk(go_cnt, g + 1);
      end else begin
         wait_idle;
         chk(go_cnt, g);
      end
   endtask
   // Two buffer words loaded low then high, then a row program reads them back
   task t_row;
      apb(1, `FPEC_OFS_BUF_ADDR, 0);
      apb(1, `FPEC_OFS_BUF_LO, 32'h0000_1234);
      apb(1, `FPEC_OFS_BUF_HI, 32'h0000_00AB);
      apb(1, `FPEC_OFS_BUF_LO, 32'h0000_5678);
      apb(1, `FPEC_OFS_BUF_HI, 32'h0000_00CD);
      run_op(0, `FPEC_OP_ROW, `FPEC_ACT_ROW_PROG);
      chk(w0, 24'hAB_1234);
      chk(w1, 24'hCD_5678);
      $display("row done");
   endtask
   task t_por;
      apb(1, `FPEC_OFS_CTRL, 32'h0000_4001);
      rst_n <= 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 32'h0000_4001);
      por_n <= 0;
      repeat (2) @(posedge mclk);
      por_n <= 1;
      apb(0, `FPEC_OFS_CTRL, 0); chk(rd, 0);
      $display("reset done");
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1; por_n <= 1;
      t_regs;
      t_err;
      run_op(1, `FPEC_OP_BULK, `FPEC_ACT_BULK_ERASE);
      run_op(1, `FPEC_OP_GSEG, `FPEC_ACT_GSEG_ERASE);
      run_op(1, `FPEC_OP_SSEG, `FPEC_ACT_SSEG_ERASE);
      run_op(1, `FPEC_OP_CFG, `FPEC_ACT_CFG_ERASE);
      run_op(1, 4'b0011, 3'd0);
      run_op(1, 4'b0001, 3'd0);
      run_op(1, 4'b0101, 3'd0);
      run_op(0, `FPEC_OP_WORD, `FPEC_ACT_WORD_PROG);
      run_op(0, 4'b1111, 3'd0);
      run_op(0, 4'b0010, 3'd0);
      run_op(0, `FPEC_OP_CFG, `FPEC_ACT_CFG_PROG_SEL);
      apb(1, `FPEC_OFS_BUF_ADDR, 32'h0000_0345);
      fast <= 1;
      run_op(1, `FPEC_OP_PAGE, `FPEC_ACT_PAGE_ERASE);
      fast <= 0;
      apb(0, `FPEC_OFS_FLASH_ADDR, 0); chk(rd, 32'h0000_0200);
      $display("ops done");
      t_row;
      t_por;
      summarize;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      summarize;
   end
endmodule
`default_nettype wire
